// *** rtl/core_ptr_pkg.sv ***
// package for the pointer, power and timer control register bank
package core_ptr_pkg;
    localparam logic [7:0] ADDR_AUX_HIGH = 8'h85;
    localparam logic [7:0] ADDR_PTR_SEL = 8'h86;
    localparam logic [7:0] ADDR_PWR_CTRL = 8'h87;
    localparam logic [7:0] ADDR_TMR_CTRL = 8'h88;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h90;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h91;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h92;
    localparam logic [7:0] RST_AUX_HIGH = 8'h00;
    localparam logic [7:0] RST_PTR_SEL = 8'h00;
    localparam logic [7:0] RST_PWR_CTRL = 8'h30;
    localparam logic [7:0] RST_TMR_CTRL = 8'h00;
    localparam logic [7:0] PWR_FIXED = 8'h30;
    localparam int SEL_BIT = 0;
    localparam int BAUD_BIT = 7;
    localparam int UF1_BIT = 3;
    localparam int UF0_BIT = 2;
    localparam int STOP_BIT = 1;
    localparam int IDLE_BIT = 0;
    localparam int TF1_BIT = 7;
    localparam int TR1_BIT = 6;
    localparam int TF0_BIT = 5;
    localparam int TR0_BIT = 4;
    localparam int IE1_BIT = 3;
    localparam int IT1_BIT = 2;
    localparam int IE0_BIT = 1;
    localparam int IT0_BIT = 0;
    localparam int EV_T0 = 0;
    localparam int EV_T1 = 1;
    localparam int EV_X0 = 2;
    localparam int EV_X1 = 3;
    localparam int EV_WIDTH = 4;
endpackage

// *** rtl/core_pointer_power_timer_ctrl.sv ***
// register bank for data pointer select, power control and timer control
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module core_pointer_power_timer_ctrl
    import core_ptr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    input wire logic timer0_ovf_i,
    input wire logic timer1_ovf_i,
    input wire logic timer0_vector_i,
    input wire logic timer1_vector_i,
    input wire logic ext_irq0_vector_i,
    input wire logic ext_irq1_vector_i,
    input wire logic ext_irq0_pin_i,
    input wire logic ext_irq1_pin_i,
    input wire logic analog_wake_i,
    input wire logic wakeup_wake_i,
    output logic active_pointer_sel_o,
    output logic [7:0] aux_pointer_high_o,
    output logic baud_doubler_o,
    output logic timer0_run_o,
    output logic timer1_run_o,
    output logic stop_mode_o,
    output logic idle_mode_o,
    output logic timer0_overflow_flag_o,
    output logic timer1_overflow_flag_o,
    output logic ext_irq0_flag_o,
    output logic ext_irq1_flag_o,
    output logic irq_o
);
    logic [1:0] x0_sync_reg, x0_sync_next;
    logic [1:0] x1_sync_reg, x1_sync_next;
    logic x0_prev_reg, x0_prev_next;
    logic x1_prev_reg, x1_prev_next;
    logic [7:0] aux_high_reg, aux_high_next;
    logic sel_reg, sel_next;
    logic baud_reg, baud_next;
    logic uf1_reg, uf1_next;
    logic uf0_reg, uf0_next;
    logic stop_reg, stop_next;
    logic idle_reg, idle_next;
    logic tf1_reg, tf1_next;
    logic tr1_reg, tr1_next;
    logic tf0_reg, tf0_next;
    logic tr0_reg, tr0_next;
    logic ie1_reg, ie1_next;
    logic it1_reg, it1_next;
    logic ie0_reg, ie0_next;
    logic it0_reg, it0_next;
    logic [3:0] stat_reg, stat_next;
    logic [3:0] en_reg, en_next;
    logic ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next;
    logic irq_reg, irq_next;
    logic x0_level, x1_level, x0_fall, x1_fall;
    logic access, wr, lane0;
    logic [7:0] wbyte;
    logic [3:0] events;

    // next values of the pin synchronisers and edge history
    always_comb begin
        x0_sync_next = {x0_sync_reg[0], ext_irq0_pin_i};
        x1_sync_next = {x1_sync_reg[0], ext_irq1_pin_i};
        x0_prev_next = x0_sync_reg[1];
        x1_prev_next = x1_sync_reg[1];
    end

    // two-flop synchronisers, reset to the idle high level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            x0_sync_reg <= 2'h3;
            x1_sync_reg <= 2'h3;
            x0_prev_reg <= 1'b1;
            x1_prev_reg <= 1'b1;
        end else begin
            x0_sync_reg <= x0_sync_next;
            x1_sync_reg <= x1_sync_next;
            x0_prev_reg <= x0_prev_next;
            x1_prev_reg <= x1_prev_next;
        end
    end

    always_comb begin
        x0_level = x0_sync_reg[1];
        x1_level = x1_sync_reg[1];
        x0_fall = x0_prev_reg & ~x0_level;
        x1_fall = x1_prev_reg & ~x1_level;
        access = cyc_i & stb_i & ~ack_reg;
        wr = access & we_i;
        lane0 = sel_i[0];
        wbyte = dat_i[7:0];
    end

    always_comb begin
        aux_high_next = aux_high_reg;
        sel_next = sel_reg;
        baud_next = baud_reg;
        uf1_next = uf1_reg;
        uf0_next = uf0_reg;
        stop_next = stop_reg;
        idle_next = idle_reg;
        tr1_next = tr1_reg;
        tr0_next = tr0_reg;
        it1_next = it1_reg;
        it0_next = it0_reg;
        tf1_next = tf1_reg;
        tf0_next = tf0_reg;
        ie1_next = ie1_reg;
        ie0_next = ie0_reg;
        en_next = en_reg;
        stat_next = stat_reg;
        if (wr && lane0) begin
            unique case (adr_i)
                ADDR_AUX_HIGH: begin
                    aux_high_next = wbyte;
                end
                ADDR_PTR_SEL: begin
                    sel_next = wbyte[SEL_BIT];
                end
                ADDR_PWR_CTRL: begin
                    baud_next = wbyte[BAUD_BIT];
                    uf1_next = wbyte[UF1_BIT];
                    uf0_next = wbyte[UF0_BIT];
                    if (wbyte[STOP_BIT]) begin
                        stop_next = 1'b1;
                    end
                    if (wbyte[IDLE_BIT]) begin
                        idle_next = 1'b1;
                    end
                end
                ADDR_TMR_CTRL: begin
                    tf1_next = wbyte[TF1_BIT];
                    tr1_next = wbyte[TR1_BIT];
                    tf0_next = wbyte[TF0_BIT];
                    tr0_next = wbyte[TR0_BIT];
                    ie1_next = wbyte[IE1_BIT];
                    it1_next = wbyte[IT1_BIT];
                    ie0_next = wbyte[IE0_BIT];
                    it0_next = wbyte[IT0_BIT];
                end
                ADDR_IRQ_CLR: begin
                    stat_next = stat_reg & ~wbyte[3:0];
                end
                ADDR_IRQ_EN: begin
                    en_next = wbyte[3:0];
                end
                default: begin
                end
            endcase
        end
        // idle exit on analog or wakeup interrupt
        if (idle_reg && (analog_wake_i || wakeup_wake_i)) begin
            idle_next = 1'b0;
        end
        // timer 0 flag cleared on vectoring
        if (timer0_vector_i) begin
            tf0_next = 1'b0;
        end
        // timer 1 flag cleared on vectoring
        if (timer1_vector_i) begin
            tf1_next = 1'b0;
        end
        if (ext_irq0_vector_i) begin
            ie0_next = 1'b0;
        end
        if (ext_irq1_vector_i) begin
            ie1_next = 1'b0;
        end
        // timer 1 overflow sets flag unless in stop mode, wins over clear
        if (timer1_ovf_i && !stop_reg) begin
            tf1_next = 1'b1;
        end
        if (timer0_ovf_i && !stop_reg) begin
            tf0_next = 1'b1;
        end
        if (it1_next) begin
            if (x1_fall) begin
                ie1_next = 1'b1;
            end
        end else begin
            ie1_next = ~x1_level;
        end
        if (it0_next) begin
            if (x0_fall) begin
                ie0_next = 1'b1;
            end
        end else begin
            ie0_next = ~x0_level;
        end
        events = 4'h0;
        events[EV_T0] = tf0_next & ~tf0_reg;
        events[EV_T1] = tf1_next & ~tf1_reg;
        events[EV_X0] = ie0_next & ~ie0_reg;
        events[EV_X1] = ie1_next & ~ie1_reg;
        stat_next = stat_next | events;
    end

    // bus answer and interrupt line
    always_comb begin
        ack_next = access;
        rdat_next = 32'h0000_0000;
        if (access && !we_i) begin
            unique case (adr_i)
                ADDR_AUX_HIGH: rdat_next[7:0] = aux_high_reg;
                ADDR_PTR_SEL: rdat_next[SEL_BIT] = sel_reg;
                // stop and idle read as 0
                ADDR_PWR_CTRL: rdat_next[7:0] = PWR_FIXED
                    | {baud_reg, 3'h0, uf1_reg, uf0_reg, 2'h0};
                ADDR_TMR_CTRL: rdat_next[7:0] = {tf1_reg, tr1_reg, tf0_reg,
                    tr0_reg, ie1_reg, it1_reg, ie0_reg, it0_reg};
                ADDR_IRQ_STAT: rdat_next[3:0] = stat_reg;
                ADDR_IRQ_EN: rdat_next[3:0] = en_reg;
                default: rdat_next = 32'h0000_0000;
            endcase
        end
        irq_next = |(stat_next & en_next);
    end

    // pointer registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // auxiliary high byte resets to zero
            aux_high_reg <= RST_AUX_HIGH;
            sel_reg <= RST_PTR_SEL[SEL_BIT];
        end else begin
            aux_high_reg <= aux_high_next;
            sel_reg <= sel_next;
        end
    end

    // power control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            baud_reg <= RST_PWR_CTRL[BAUD_BIT];
            uf1_reg <= RST_PWR_CTRL[UF1_BIT];
            uf0_reg <= RST_PWR_CTRL[UF0_BIT];
            stop_reg <= 1'b0;
            idle_reg <= 1'b0;
        end else begin
            baud_reg <= baud_next;
            uf1_reg <= uf1_next;
            uf0_reg <= uf0_next;
            stop_reg <= stop_next;
            idle_reg <= idle_next;
        end
    end

    // timer and external interrupt control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tf1_reg <= RST_TMR_CTRL[TF1_BIT];
            tr1_reg <= RST_TMR_CTRL[TR1_BIT];
            tf0_reg <= RST_TMR_CTRL[TF0_BIT];
            tr0_reg <= RST_TMR_CTRL[TR0_BIT];
            ie1_reg <= RST_TMR_CTRL[IE1_BIT];
            it1_reg <= RST_TMR_CTRL[IT1_BIT];
            ie0_reg <= RST_TMR_CTRL[IE0_BIT];
            it0_reg <= RST_TMR_CTRL[IT0_BIT];
        end else begin
            tf1_reg <= tf1_next;
            tr1_reg <= tr1_next;
            tf0_reg <= tf0_next;
            tr0_reg <= tr0_next;
            ie1_reg <= ie1_next;
            it1_reg <= it1_next;
            ie0_reg <= ie0_next;
            it0_reg <= it0_next;
        end
    end

    // interrupt status, enable and line
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_reg <= 4'h0;
            en_reg <= 4'h0;
            irq_reg <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            en_reg <= en_next;
            irq_reg <= irq_next;
        end
    end

    // bus acknowledge and read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
        end
    end

    assign active_pointer_sel_o = sel_reg;
    assign aux_pointer_high_o = aux_high_reg;
    assign baud_doubler_o = baud_reg;
    assign timer1_run_o = tr1_reg;
    assign timer0_run_o = tr0_reg;
    assign stop_mode_o = stop_reg;
    assign idle_mode_o = idle_reg;
    assign timer0_overflow_flag_o = tf0_reg;
    assign timer1_overflow_flag_o = tf1_reg;
    assign ext_irq0_flag_o = ie0_reg;
    assign ext_irq1_flag_o = ie1_reg;
    assign ack_o = ack_reg;
    assign dat_o = rdat_reg;
    assign irq_o = irq_reg;
endmodule
`default_nettype wire

// *** tb/irq_pin_source.sv ***
// external interrupt pins and timer overflow source
`timescale 1ns/1ps
`default_nettype none
module irq_pin_source (
    input wire logic clk_i,
    output logic [1:0] pin_o,
    output logic [1:0] ovf_o
);
    // pins idle high on their pull-ups
    initial begin
        pin_o = 2'b11;
        ovf_o = 2'b00;
    end
    task drive(input int n, input logic v);
        @(posedge clk_i);
        pin_o[n] <= v;
    endtask
    task ovf(input int n);
        @(posedge clk_i);
        ovf_o[n] <= 1'b1;
        @(posedge clk_i);
        ovf_o[n] <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** tb/core_ptr_asserts.sv ***
// port assertions for the pointer, power and timer register bank
`timescale 1ns/1ps
`default_nettype none
module core_ptr_asserts
    import core_ptr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic timer0_ovf_i,
    input wire logic timer1_ovf_i,
    input wire logic analog_wake_i,
    input wire logic wakeup_wake_i,
    input wire logic stop_mode_o,
    input wire logic idle_mode_o,
    input wire logic timer0_overflow_flag_o,
    input wire logic timer1_overflow_flag_o,
    input wire logic active_pointer_sel_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_ack(w, a);
        ack_o && we_i == w && adr_i == a;
    endsequence
    property p_ack;
        s_take |=> ack_o ##1 !ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle");
    property p_sel;
        s_ack(1'b1, ADDR_PTR_SEL) and sel_i[0]
            |-> active_pointer_sel_o == dat_i[0];
    endproperty
    a_sel: assert property (p_sel) else $error("select not written");
    property p_pwr;
        s_ack(1'b0, ADDR_PWR_CTRL) |-> (dat_o[5:0] & 6'h33) == 6'h30;
    endproperty
    a_pwr: assert property (p_pwr) else $error("power read bits");
    property p_stop;
        stop_mode_o |=> stop_mode_o;
    endproperty
    a_stop: assert property (p_stop) else $error("stop left early");
    property p_t0;
        timer0_ovf_i && !stop_mode_o |=> timer0_overflow_flag_o;
    endproperty
    a_t0: assert property (p_t0) else $error("timer 0 flag missed");
    property p_t1;
        timer1_ovf_i && !stop_mode_o |=> timer1_overflow_flag_o;
    endproperty
    a_t1: assert property (p_t1) else $error("timer 1 flag missed");
    property p_wake;
        idle_mode_o && (analog_wake_i || wakeup_wake_i) |=> !idle_mode_o;
    endproperty
    a_wake: assert property (p_wake) else $error("idle not left");
    property p_hold;
        ack_o |-> dat_o[31:8] == 24'h0;
    endproperty
    a_hold: assert property (p_hold) else $error("upper lanes not zero");
endmodule
bind core_pointer_power_timer_ctrl core_ptr_asserts i_chk (.clk_i, .rst_i,
    .cyc_i, .stb_i, .we_i, .sel_i, .adr_i, .dat_i, .dat_o, .ack_o,
    .timer0_ovf_i, .timer1_ovf_i, .analog_wake_i, .wakeup_wake_i,
    .stop_mode_o, .idle_mode_o, .timer0_overflow_flag_o,
    .timer1_overflow_flag_o, .active_pointer_sel_o);
`default_nettype wire

// *** tb/core_pointer_power_timer_ctrl_tb.sv ***
// self-checking bench for the pointer, power and timer register bank
`timescale 1ns/1ps
`default_nettype none
module core_pointer_power_timer_ctrl_tb import core_ptr_pkg::*;;
    logic clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0;
    logic [7:0] adr_i = 0, aux, q;
    logic [31:0] dat_i = 0, dat_o;
    logic [3:0] sel_i = 4'hF, vec = 0;
    logic [1:0] wake = 0, pin, ovf, xf;
    logic ack, ps, bd, r0, r1, stp, idl, f0, f1, irq;
    int num_errors = 0, n_tests = 0;
    irq_pin_source m (.clk_i(clk_i), .pin_o(pin), .ovf_o(ovf));
    core_pointer_power_timer_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i),
        .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack),
        .timer0_ovf_i(ovf[0]), .timer1_ovf_i(ovf[1]),
        .timer0_vector_i(vec[0]), .timer1_vector_i(vec[1]),
        .ext_irq0_vector_i(vec[2]), .ext_irq1_vector_i(vec[3]),
        .ext_irq0_pin_i(pin[0]), .ext_irq1_pin_i(pin[1]),
        .analog_wake_i(wake[0]), .wakeup_wake_i(wake[1]),
        .active_pointer_sel_o(ps), .aux_pointer_high_o(aux),
        .baud_doubler_o(bd), .timer0_run_o(r0), .timer1_run_o(r1),
        .stop_mode_o(stp), .idle_mode_o(idl),
        .timer0_overflow_flag_o(f0), .timer1_overflow_flag_o(f1),
        .ext_irq0_flag_o(xf[0]), .ext_irq1_flag_o(xf[1]), .irq_o(irq));
    initial forever #20 clk_i = ~clk_i;
    task end_sim;
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int i;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 24'h0, d};
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (ack !== 1'b1 && i < 50);
        q = dat_o[7:0];
        {cyc_i, stb_i, we_i} <= 3'b000;
        if (i >= 50) begin
            num_errors++;
            end_sim();
        end
    endtask
    task rdc(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(q, e);
    endtask
    task tick(input int k);
        repeat (k) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task pulse(input int k);
        @(posedge clk_i);
        vec[k] <= 1'b1;
        @(posedge clk_i);
        vec[k] <= 1'b0;
        tick(0);
    endtask
    task do_reset;
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    task t_regs;
        rdc(ADDR_AUX_HIGH, RST_AUX_HIGH);
        rdc(ADDR_PTR_SEL, RST_PTR_SEL);
        rdc(ADDR_PWR_CTRL, RST_PWR_CTRL);
        rdc(ADDR_TMR_CTRL, RST_TMR_CTRL);
        bus(1'b1, 8'h89, 8'hFF);
        rdc(8'h89, 8'h00);
        bus(1'b1, ADDR_AUX_HIGH, 8'hA5);
        rdc(ADDR_AUX_HIGH, 8'hA5);
        chk(aux, 8'hA5);
        bus(1'b1, ADDR_PTR_SEL, 8'hFF);
        rdc(ADDR_PTR_SEL, 8'h01);
        sel_i <= 4'hE;
        bus(1'b1, ADDR_PTR_SEL, 8'h00);
        chk(ps, 1'b1);
        sel_i <= 4'hF;
        bus(1'b1, ADDR_PTR_SEL, 8'h00);
        chk(ps, 1'b0);
        $display("registers done");
    endtask
    task t_power;
        int k;
        bus(1'b1, ADDR_PWR_CTRL, 8'h8C);
        rdc(ADDR_PWR_CTRL, 8'hBC);
        chk(bd, 1'b1);
        for (k = 0; k < 2; k++) begin
            bus(1'b1, ADDR_PWR_CTRL, 8'h8D);
            tick(0);
            chk(idl, 1'b1);
            rdc(ADDR_PWR_CTRL, 8'hBC);
            @(posedge clk_i);
            wake[k] <= 1'b1;
            tick(2);
            chk(idl, 1'b0);
            @(posedge clk_i);
            wake[k] <= 1'b0;
        end
        $display("power done");
    endtask
    task t_timer;
        bus(1'b1, ADDR_TMR_CTRL, 8'h50);
        chk({r1, r0}, 2'b11);
        m.ovf(0);
        tick(0);
        chk(f0, 1'b1);
        rdc(ADDR_TMR_CTRL, 8'h70);
        pulse(0);
        chk(f0, 1'b0);
        m.ovf(1);
        tick(0);
        chk(f1, 1'b1);
        pulse(1);
        chk(f1, 1'b0);
        bus(1'b1, ADDR_TMR_CTRL, 8'h00);
        chk({r1, r0}, 2'b00);
        $display("timer done");
    endtask
    task t_ext(input int n);
        bus(1'b1, ADDR_TMR_CTRL, n ? 8'h04 : 8'h01);
        m.drive(n, 1'b0);
        m.drive(n, 1'b1);
        tick(5);
        chk(xf[n], 1'b1);
        rdc(ADDR_TMR_CTRL, n ? 8'h0C : 8'h03);
        pulse(n + 2);
        chk(xf[n], 1'b0);
        bus(1'b1, ADDR_TMR_CTRL, 8'h00);
        m.drive(n, 1'b0);
        tick(5);
        chk(xf[n], 1'b1);
        m.drive(n, 1'b1);
        tick(5);
        chk(xf[n], 1'b0);
        $display("external done");
    endtask
    task t_irq;
        bus(1'b1, ADDR_IRQ_CLR, 8'h0F);
        bus(1'b1, ADDR_IRQ_EN, 8'h01);
        tick(1);
        chk(irq, 1'b0);
        m.ovf(0);
        tick(2);
        chk(irq, 1'b1);
        rdc(ADDR_IRQ_STAT, 8'h01);
        bus(1'b1, ADDR_IRQ_EN, 8'h00);
        tick(1);
        chk(irq, 1'b0);
        bus(1'b1, ADDR_IRQ_CLR, 8'h0F);
        rdc(ADDR_IRQ_STAT, 8'h00);
        pulse(0);
        $display("interrupt done");
    endtask
    task t_stop;
        bus(1'b1, ADDR_PWR_CTRL, 8'h02);
        tick(0);
        chk(stp, 1'b1);
        m.ovf(0);
        tick(2);
        chk({stp, f0}, 2'b10);
        do_reset();
        tick(0);
        chk(stp, 1'b0);
        $display("stop done");
    endtask
    initial begin
        do_reset();
        t_regs();
        t_power();
        t_timer();
        t_ext(0);
        t_ext(1);
        t_irq();
        t_stop();
        end_sim();
    end
endmodule
`default_nettype wire
